//--- verilog/scl_pkg.sv
// package for the serial configuration load controller
`default_nettype none
package scl_pkg;
	// length counter width
	localparam int LEN_W = 24;
	// clock rate and timing
	localparam int CLK_MHZ = 100;
	localparam int PROG_FILTER_US = 2;
	localparam int PROG_FILTER_CYC = PROG_FILTER_US * CLK_MHZ;
	localparam int FORCE_CLEAR_US = 6;
	localparam int FORCE_CLEAR_CYC = FORCE_CLEAR_US * CLK_MHZ;
	localparam int TMR_W = 10;
	// extra clocks after length count
	localparam logic [1:0] EXTRA_CLKS = 2'h3;
	// memory model size in bits
	localparam int MEM_W = 8;
	localparam logic [LEN_W-1:0] LEN_RST = 24'hFFFFFF;
	// mode select encoding
	localparam logic [2:0] MODE_PERIPH = 3'h5;
	localparam logic [2:0] MODE_SLAVE = 3'h7;
	// readback option encoding
	localparam logic [1:0] RB_CMD = 2'h0;
	localparam logic [1:0] RB_ONCE = 2'h1;
	localparam logic [1:0] RB_NEVER = 2'h2;
	// host decode group
	typedef struct packed {
		logic write_strobe_n;
		logic cs_a_n;
		logic cs_b_n;
		logic cs_c_hi;
	} scl_host_t;
	// controller states
	typedef enum logic [2:0] {
		S_CLEAR, S_LEN, S_LOAD, S_START0, S_START1, S_START2, S_RUN, S_PDOWN
	} scl_state_t;
endpackage
`default_nettype wire

//--- verilog/scl_loader.sv
// serial configuration load controller top
`default_nettype none
// Functional notes
// - write decoded only when strobe and both low selects low, high select high
// - each decoded write moves exactly one bit, bitstream order
// - slave mode samples data on each rising configuration clock
// - slave takes data from upstream chain output and lead clock
// - length count covers all devices in the chain
// - chain output held high while loading own configuration
// - after own memory full, data forwarded on chain output
// - lead device drives downstream clock from write timing
// - start-up: reset, then outputs enable, then done
// - reprogram returns to clear: erase, disable I/O, resample mode
// - device holds done pin low until reload finished
// - device starts on completion even if done pin held low
// - reprogram request filtered for stability before acting
// - reprogram clear timeout has no fourfold lengthening
// - reset and done pin low together for 6 us force clear
// - power-down clears state, keeps configuration, outputs off
// - loading refused during power-down
// - leaving power-down runs start-up without reload
// - readback permission: every command, once, or never
// - 24-bit length counter cleared, counts clocks, compares loaded count
// - loading indicators released one clock before done
// - peripheral data captured at trailing edge of write condition
module scl_loader
	import scl_pkg::*;
(
	// clock and reset
	input  wire logic             I_CLK,
	input  wire logic             I_RST_N,
	input  wire logic             I_CE,
	// mode and host decode
	input  wire logic [2:0]       I_MODE,
	input  wire scl_pkg::scl_host_t I_HOST,
	input  wire logic             I_DATA,
	// slave configuration clock, sampled
	input  wire logic             I_CFG_CLK,
	// done/reprogram open drain and system reset
	input  wire logic             I_DONE_PIN,
	input  wire logic             I_SYS_RESET_N,
	input  wire logic             I_POWER_DOWN_N,
	// readback trigger
	input  wire logic             I_RB_TRIG,
	// chain outputs
	output logic                  O_CHAIN_DATA,
	output logic                  O_CHAIN_CLK,
	// status outputs
	output logic                  O_DONE_PIN_OE,
	output logic                  O_HIGH_WHILE_LOADING,
	output logic                  O_LOW_WHILE_LOADING_N,
	output logic                  O_USER_RESET,
	output logic                  O_IO_ENABLE,
	output logic                  O_MEM_CLEAR,
	output logic                  O_RB_GRANT,
	output logic [MEM_W-1:0]      O_CFG_MEM
);
	import scl_pkg::*;

	logic             rst_s1_q;
	logic             rst_n_q;
	scl_state_t       state_q;
	logic [2:0]       mode_q;
	logic             wr_q;
	logic             cfg_s1_q;
	logic             cfg_s2_q;
	logic             cfg_s3_q;
	logic             bit_ev;
	logic             bit_val;
	logic [LEN_W-1:0] len_q;
	logic [LEN_W-1:0] cnt_q;
	logic [4:0]       len_bits_q;
	logic [3:0]       mem_cnt_q;
	logic             mem_full;
	logic [TMR_W-1:0] prog_tmr_q;
	logic             prog_req;
	logic [TMR_W-1:0] force_tmr_q;
	logic             force_clr;
	logic             prog_go;
	logic             prog_arm_q;
	logic             resume_q;
	logic             start_step;
	logic [LEN_W-1:0] cnt_nxt;
	logic [1:0]       rb_opt_q;
	logic             rb_used_q;
	logic             trig_q;
	logic             data_q;

	// saturating timer increment, shared by both filters
	function automatic logic [TMR_W-1:0] tmr_step(input logic [TMR_W-1:0] t, input logic go);
		if (!go)
			return '0;
		return (t == {TMR_W{1'b1}}) ? t : t + 10'h001;
	endfunction

	// reset release through two flops
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// peripheral write decode, inputs already synchronous
	wire wr_now = !I_HOST.write_strobe_n && !I_HOST.cs_a_n
		&& !I_HOST.cs_b_n && I_HOST.cs_c_hi;
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_q   <= 1'b0;
			data_q <= 1'b0;
		end else if (I_CE) begin
			wr_q   <= wr_now;
			data_q <= I_DATA;
		end
	end

	// slave clock edge detection after two-flop sync
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cfg_s1_q <= 1'b0;
			cfg_s2_q <= 1'b0;
			cfg_s3_q <= 1'b0;
		end else if (I_CE) begin
			cfg_s1_q <= I_CFG_CLK;
			cfg_s2_q <= cfg_s1_q;
			cfg_s3_q <= cfg_s2_q;
		end
	end

	// one bit event per trailing write edge or rising slave clock
	always_comb begin
		bit_ev  = 1'b0;
		bit_val = data_q;
		if (!I_POWER_DOWN_N) begin
			bit_ev = 1'b0;
		end else if (mode_q == MODE_PERIPH) begin
			bit_ev = wr_q && !wr_now;
		end else if (mode_q == MODE_SLAVE) begin
			bit_ev = cfg_s2_q && !cfg_s3_q;
		end
	end

	// reprogram filter on done pin, force clear with system reset
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prog_tmr_q  <= '0;
			force_tmr_q <= '0;
		end else if (I_CE) begin
			prog_tmr_q  <= tmr_step(prog_tmr_q, prog_go);
			force_tmr_q <= tmr_step(force_tmr_q, !I_DONE_PIN && !I_SYS_RESET_N);
		end
	end
	assign prog_req  = prog_tmr_q >= TMR_W'(PROG_FILTER_CYC);
	assign force_clr = force_tmr_q >= TMR_W'(FORCE_CLEAR_CYC);
	assign mem_full  = mem_cnt_q == 4'(MEM_W);
	assign prog_go   = !I_DONE_PIN && state_q == S_RUN && prog_arm_q;
	assign cnt_nxt   = cnt_q + 24'h000001;

	// filter arms only once the pin reads high in run, so a pin held low
	// from outside through the load does not restart configuration
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			prog_arm_q <= 1'b0;
		end else if (I_CE) begin
			if (state_q != S_RUN) begin
				prog_arm_q <= 1'b0;
			end else if (I_DONE_PIN) begin
				prog_arm_q <= 1'b1;
			end
		end
	end

	// power-down return steps start-up on the system clock, no config bits
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			resume_q <= 1'b0;
		end else if (I_CE) begin
			if (state_q == S_PDOWN) begin
				resume_q <= 1'b1;
			end else if (state_q == S_RUN || state_q == S_CLEAR) begin
				resume_q <= 1'b0;
			end
		end
	end
	assign start_step = bit_ev || resume_q;

	// main sequencer
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= S_CLEAR;
			mode_q  <= MODE_SLAVE;
		end else if (I_CE) begin
			if (force_clr || prog_req) begin
				state_q <= S_CLEAR;
			end else begin
				case (state_q)
					S_CLEAR: begin
						mode_q <= I_MODE; // resample mode
						// clear is one cycle, no fourfold wait
						state_q <= I_POWER_DOWN_N ? S_LEN : S_CLEAR;
					end
					S_LEN: if (bit_ev && len_bits_q == 5'(LEN_W - 1)) state_q <= S_LOAD;
					S_LOAD: if (bit_ev && cnt_nxt == len_q) state_q <= S_START0;
					S_START0: if (bit_ev) state_q <= S_START1;
					S_START1: if (start_step) state_q <= S_START2;
					S_START2: if (start_step) state_q <= S_RUN;
					S_RUN: if (!I_POWER_DOWN_N) state_q <= S_PDOWN;
					S_PDOWN: if (I_POWER_DOWN_N) state_q <= S_START1;
					default: state_q <= S_CLEAR;
				endcase
			end
		end
	end

	// length count capture and counter
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			len_q      <= LEN_RST;
			cnt_q      <= '0;
			len_bits_q <= '0;
		end else if (I_CE) begin
			if (state_q == S_CLEAR) begin
				cnt_q      <= '0;
				len_bits_q <= '0;
			end else if (bit_ev && state_q != S_RUN && state_q != S_PDOWN) begin
				cnt_q <= cnt_nxt;
				if (state_q == S_LEN) begin
					len_q      <= {len_q[LEN_W-2:0], bit_val};
					len_bits_q <= len_bits_q + 5'h01;
				end
			end
		end
	end

	// own memory shift, then chain forwarding
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_CFG_MEM    <= '0;
			mem_cnt_q    <= '0;
			O_CHAIN_DATA <= 1'b1;
			O_CHAIN_CLK  <= 1'b0;
		end else if (I_CE) begin
			O_CHAIN_CLK <= bit_ev && mode_q == MODE_PERIPH;
			if (state_q == S_CLEAR) begin
				O_CFG_MEM    <= '0;
				mem_cnt_q    <= '0;
				O_CHAIN_DATA <= 1'b1;
			end else if (bit_ev && state_q == S_LEN) begin
				O_CHAIN_DATA <= bit_val; // preamble passes downstream
			end else if (bit_ev && state_q == S_LOAD) begin
				if (!mem_full) begin
					O_CFG_MEM    <= {O_CFG_MEM[MEM_W-2:0], bit_val};
					mem_cnt_q    <= mem_cnt_q + 4'h1;
					O_CHAIN_DATA <= 1'b1;
				end else begin
					O_CHAIN_DATA <= bit_val;
				end
			end
		end
	end

	// start-up outputs and done pin drive
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_USER_RESET          <= 1'b1;
			O_IO_ENABLE           <= 1'b0;
			O_DONE_PIN_OE         <= 1'b1;
			O_HIGH_WHILE_LOADING  <= 1'b1;
			O_LOW_WHILE_LOADING_N <= 1'b0;
			O_MEM_CLEAR           <= 1'b1;
		end else if (I_CE) begin
			O_MEM_CLEAR <= state_q == S_CLEAR;
			// outputs follow state; done ignores external low
			O_USER_RESET <= !(state_q == S_START1 || state_q == S_START2
				|| state_q == S_RUN);
			O_IO_ENABLE <= state_q == S_START2 || state_q == S_RUN;
			O_DONE_PIN_OE <= state_q != S_RUN && state_q != S_PDOWN;
			O_HIGH_WHILE_LOADING  <= !(state_q == S_START2 || state_q == S_RUN
				|| state_q == S_PDOWN);
			O_LOW_WHILE_LOADING_N <= state_q == S_START2 || state_q == S_RUN
				|| state_q == S_PDOWN;
		end
	end

	// readback option and grant
	always_ff @(posedge I_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rb_opt_q   <= RB_NEVER;
			rb_used_q  <= 1'b0;
			trig_q     <= 1'b0;
			O_RB_GRANT <= 1'b0;
		end else if (I_CE) begin
			trig_q     <= I_RB_TRIG;
			O_RB_GRANT <= 1'b0;
			if (state_q == S_START0) begin
				rb_opt_q  <= O_CFG_MEM[1:0]; // option from configuration
				rb_used_q <= 1'b0;
			end else if (state_q == S_RUN && I_RB_TRIG && !trig_q) begin
				if (rb_opt_q == RB_CMD || (rb_opt_q == RB_ONCE && !rb_used_q)) begin
					O_RB_GRANT <= 1'b1;
					rb_used_q  <= 1'b1;
				end
			end
		end
	end

	// checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!rst_n_q);
	one_bit_write_a: assert property (
		I_CE && mode_q == MODE_PERIPH && wr_q && !wr_now && I_POWER_DOWN_N |=> O_CHAIN_CLK)
		else $error("write without clock");
	no_spur_clk_a: assert property (
		I_CE && !bit_ev |=> !O_CHAIN_CLK)
		else $error("spurious chain clock");
	decode_a: assert property (
		mode_q == MODE_PERIPH && I_HOST.cs_c_hi == 1'b0 && $past(I_HOST.cs_c_hi) == 1'b0
		|-> !bit_ev) else $error("bad decode");
	pdown_a: assert property (
		!I_POWER_DOWN_N |-> !bit_ev)
		else $error("load in power down");
	startup_a: assert property (
		I_CE && state_q == S_START2 && bit_ev && !force_clr && !prog_req |=> state_q == S_RUN)
		else $error("start-up order");
	io_before_done_a: assert property (
		I_CE && state_q == S_START2 |=> O_IO_ENABLE && O_DONE_PIN_OE)
		else $error("io not before done");
	done_drive_a: assert property (
		I_CE && state_q == S_LOAD |=> O_DONE_PIN_OE)
		else $error("done released while loading");
	run_release_a: assert property (
		I_CE && state_q == S_RUN |=> !O_DONE_PIN_OE)
		else $error("done held in run");
	chain_high_a: assert property (
		I_CE && state_q == S_LOAD && bit_ev && !mem_full && !force_clr |=> O_CHAIN_DATA)
		else $error("chain not high");
	clear_a: assert property (
		I_CE && (force_clr || prog_req) |=> state_q == S_CLEAR)
		else $error("no clear");
	never_rb_a: assert property (
		rb_opt_q == RB_NEVER && I_CE |=> !O_RB_GRANT)
		else $error("readback granted");
	resume_step_a: assert property (
		I_CE && state_q == S_START1 && resume_q && !force_clr && !prog_req |=> state_q == S_START2)
		else $error("power-down start-up stalled");
	held_pin_a: assert property (
		I_CE && state_q == S_RUN && !prog_arm_q |=> !prog_req)
		else $error("held done pin restarted load");
	load_c: cover property (state_q == S_LOAD ##1 state_q == S_START0);
	run_c: cover property (state_q == S_START2 ##1 state_q == S_RUN);
	pd_c: cover property (state_q == S_PDOWN ##1 state_q == S_START1);
	rb_c: cover property (O_RB_GRANT);
	force_c: cover property (force_clr);
endmodule
`default_nettype wire

//--- sim/scl_host_model.sv
// host processor and upstream clock source driving the loader
`default_nettype none
module scl_host_model
	import scl_pkg::*;
(
	// clock and observed chain outputs
	input  wire logic        i_clk,
	input  wire logic        i_chain_clk,
	input  wire logic        i_chain_data,
	// drive toward the loader
	output var scl_pkg::scl_host_t o_host,
	output logic             o_data,
	output logic             o_cfg_clk
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle decode, no slave clock
	initial begin
		o_host = 4'hE;
		o_data = 1'b0;
		o_cfg_clk = 1'b0;
	end

	// one bit per write or per rising slave clock, then watch for the chain pulse
	task automatic send_bit(input logic b, input logic sl, input logic bad,
		output logic p, output logic cd);
		@(posedge i_clk);
		o_data <= b;
		o_host <= sl ? 4'hE : (bad ? 4'h0 : 4'h1);
		o_cfg_clk <= sl;
		repeat (3) @(posedge i_clk);
		o_host <= 4'hE;
		o_cfg_clk <= 1'b0;
		p = 1'b0;
		cd = 1'b0;
		for (int i = 0; i < 6; i++) begin
			@(posedge i_clk);
			if (i == 1) o_data <= ~b; // data no longer held, show inverse
			if (i_chain_clk === 1'b1) begin
				p = 1'b1;
				cd = i_chain_data;
			end
		end
	endtask
endmodule
`default_nettype wire

//--- sim/test_serial_config_load_control.sv
// self-checking bench for the serial configuration load controller
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD %0t got %h want %h", $time, (a), (b)); end end
module test_serial_config_load_control;
	import scl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk, rst_n, sys_rst_n, pdn_n, rb_trig, ext_low, done_pin;
	logic [2:0]       mode;
	scl_host_t        host;
	logic             data, cfg_clk, ch_data, ch_clk, done_oe, hwl, lwl_n;
	logic             usr_rst, io_en, mem_clr, rb_grant, p, cd, ce;
	logic [MEM_W-1:0] mem;
	int               num_errors, n_checks, cyc, n_grants;

	// open-drain done wire with pull-up
	assign done_pin = ~(ext_low | done_oe);

	scl_loader dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_MODE(mode),
		.I_HOST(host), .I_DATA(data), .I_CFG_CLK(cfg_clk), .I_DONE_PIN(done_pin),
		.I_SYS_RESET_N(sys_rst_n), .I_POWER_DOWN_N(pdn_n), .I_RB_TRIG(rb_trig),
		.O_CHAIN_DATA(ch_data), .O_CHAIN_CLK(ch_clk), .O_DONE_PIN_OE(done_oe),
		.O_HIGH_WHILE_LOADING(hwl), .O_LOW_WHILE_LOADING_N(lwl_n),
		.O_USER_RESET(usr_rst), .O_IO_ENABLE(io_en), .O_MEM_CLEAR(mem_clr),
		.O_RB_GRANT(rb_grant), .O_CFG_MEM(mem));

	scl_host_model hm_u (.i_clk(clk), .i_chain_clk(ch_clk), .i_chain_data(ch_data),
		.o_host(host), .o_data(data), .o_cfg_clk(cfg_clk));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// timeout and grant watch
	always @(posedge clk) begin
		cyc++;
		if (rb_grant === 1'b1) n_grants++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// length 36 covers length, own byte and four forwarded bits
	task automatic load(input logic sl, input logic [7:0] m);
		logic [35:0] s;
		s = {24'h000024, m, 4'hB};
		for (int i = 35; i >= 0; i--) begin
			hm_u.send_bit(s[i], sl, 1'b0, p, cd);
			if (!sl) `CHK(p, 1'b1);
			if (!sl && i >= 4 && i < 12) `CHK(cd, 1'b1);
			if (!sl && i < 4) `CHK(cd, s[i]);
		end
		`CHK(mem, m);
		hm_u.send_bit(1'b0, sl, 1'b0, p, cd);
		hm_u.send_bit(1'b0, sl, 1'b0, p, cd);
		`CHK(io_en, 1'b1);
		`CHK(hwl, 1'b0);
		`CHK(lwl_n, 1'b1);
		`CHK(done_oe, 1'b1);
		hm_u.send_bit(1'b0, sl, 1'b0, p, cd);
		`CHK(done_oe, 1'b0);
		`CHK(usr_rst, 1'b0);
	endtask

	// main sequence
	initial begin
		{rst_n, rb_trig, ext_low} = 3'h0;
		{sys_rst_n, pdn_n, ce} = 3'h7;
		mode = MODE_PERIPH;
		repeat (6) @(posedge clk);
		`CHK(mem_clr, 1'b1);
		`CHK(io_en, 1'b0);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		hm_u.send_bit(1'b1, 1'b0, 1'b1, p, cd);
		`CHK(p, 1'b0);
		load(1'b0, 8'hA2);
		rb_trig <= 1'b1;
		repeat (10) @(posedge clk);
		rb_trig <= 1'b0;
		`CHK(n_grants, 0);
		// frozen clock enable keeps the run state through a power-down request
		ce <= 1'b0;
		pdn_n <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(io_en, 1'b1);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(io_en, 1'b0);
		hm_u.send_bit(1'b1, 1'b0, 1'b0, p, cd);
		`CHK(p, 1'b0);
		pdn_n <= 1'b1;
		repeat (12) @(posedge clk);
		`CHK(io_en, 1'b1);
		`CHK(done_oe, 1'b0);
		`CHK(mem, 8'hA2);
		ext_low <= 1'b1;
		repeat (50) @(posedge clk);
		ext_low <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(io_en, 1'b1);
		ext_low <= 1'b1;
		mode <= MODE_SLAVE;
		repeat (250) @(posedge clk);
		`CHK(done_oe, 1'b1);
		`CHK(mem, 8'h00);
		`CHK(io_en, 1'b0);
		load(1'b1, 8'h50);
		`CHK(io_en, 1'b1);
		// done pin still held low well past the filter time
		repeat (250) @(posedge clk);
		`CHK(io_en, 1'b1);
		`CHK(done_oe, 1'b0);
		ext_low <= 1'b0;
		// every-command option grants each trigger
		repeat (2) begin
			rb_trig <= 1'b1;
			repeat (10) @(posedge clk);
			rb_trig <= 1'b0;
			repeat (10) @(posedge clk);
		end
		`CHK(n_grants, 2);
		// system reset with done pin low keeps the clear state
		sys_rst_n <= 1'b0;
		ext_low <= 1'b1;
		repeat (610) @(posedge clk);
		`CHK(mem_clr, 1'b1);
		`CHK(mem, 8'h00);
		sys_rst_n <= 1'b1;
		ext_low <= 1'b0;
		repeat (5) @(posedge clk);
		load(1'b1, 8'h51);
		// single-use option grants only the first trigger
		repeat (2) begin
			rb_trig <= 1'b1;
			repeat (10) @(posedge clk);
			rb_trig <= 1'b0;
			repeat (10) @(posedge clk);
		end
		`CHK(n_grants, 3);
		results();
	end
endmodule
`default_nettype wire
